// *** src/dmag_pkg.sv ***
// Shared constants and carrier types for the data memory address generator
package dmag_pkg;

    // ------------------------------------------------------------------
    // Address space
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 8;
    localparam logic [BANK_W-1:0] SPECIAL_BANK = 4'hf;
    localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;
    localparam int IMPL_BANKS = 2;
    localparam int BANK_BYTES = 256;
    localparam int SPECIAL_BYTES = 128;
    localparam int RAM_DEPTH = IMPL_BANKS * BANK_BYTES + SPECIAL_BYTES;
    localparam int RAM_AW = 10;
    localparam logic [RAM_AW-1:0] SPECIAL_RAM_BASE =
        RAM_AW'(IMPL_BANKS * BANK_BYTES);

    // ------------------------------------------------------------------
    // Indirect ports: addr[11:5] page, addr[4:3] pointer, addr[2:0] kind
    // ------------------------------------------------------------------
    localparam int NUM_PTR = 3;
    localparam logic [6:0] PORT_PAGE = 7'h7f;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;

    typedef enum logic [2:0] {
        PK_PLAIN = 3'b000,
        PK_AFTER_DOWN = 3'b001,
        PK_AFTER_UP = 3'b010,
        PK_BEFORE_UP = 3'b011,
        PK_OFFSET = 3'b100
    } dmag_port_kind_t;

    // ------------------------------------------------------------------
    // Wishbone register map (byte offsets, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] WB_BANK_OFS = 8'h00;
    localparam logic [7:0] WB_PTR0_OFS = 8'h04;
    localparam int WB_PTR_STRIDE = 4;
    localparam logic [7:0] WB_STAT_OFS = 8'h10;
    localparam int STAT_BUSY_BIT = 16;

    // ------------------------------------------------------------------
    // Operations, states and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_MOVE = 2'b10,
        OP_LOAD_BANK = 2'b11
    } dmag_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_READ = 1'b1
    } dmag_state_t;

    typedef struct packed {
        logic valid;
        dmag_op_t op;
        logic accessBit;
        logic [OFFS_W-1:0] offset;
        logic [ADDR_W-1:0] srcAddr;
        logic [ADDR_W-1:0] dstAddr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] working;
    } dmag_req_t;

    typedef struct packed {
        logic done;
        logic blocked;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] rdata;
    } dmag_resp_t;

    typedef struct packed {
        logic usePtr;
        logic update;
        logic [1:0] ptrSel;
        logic [ADDR_W-1:0] ptrNew;
        logic [ADDR_W-1:0] eff;
        logic blocked;
    } dmag_res_t;

endpackage

// *** src/dmag_data_ram.sv ***
// Byte-wide data RAM with registered read data
`timescale 1ns/1ps
`default_nettype none

module dmag_data_ram
    import dmag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rdEn,
    input wire logic wrEn,
    input wire logic [RAM_AW-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem [RAM_DEPTH];
    logic [DATA_W-1:0] rdata_reg;

    // Array has no reset so it can map onto plain static RAM
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[addr] <= wdata;
        end
    end

    // Read data held in a register; it keeps its value between reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (rdEn) begin
            rdata_reg <= mem[addr];
        end
    end

    assign rdata = rdata_reg;

endmodule

`default_nettype wire

// *** src/dmag_addr_gen.sv ***
// Data memory address generator: banked, access-window and indirect modes
//
// Behaviour
// - Access window uses top 128 bytes of bank 15 and bottom 128 of bank 0.
// - Access bit zero selects the access window, otherwise the bank register.
// - Window's upper half follows the lower half, one contiguous 256 bytes.
// - Special registers reachable through the window without touching bank.
// - Sixteen banks; bank bits 3:0 are address bits 11:8.
// - Bank register bits 7:4 read zero and ignore writes.
// - Unimplemented bank reads zero, drops writes; flags still updated by ALU.
// - Each bank holds 256 bytes by 8-bit offset; all memory is static RAM.
// - File-to-file move ignores bank and uses its full 12-bit addresses.
// - Indirect port access goes to the pointer's address; port stores nothing.
// - Each pointer holds a full 12-bit address reaching all RAM linearly.
// - Indirect read of an indirect port itself returns 00h.
// - Indirect write of an indirect port itself is a no-op.
// - Ports per pointer: plain, post-dec, post-inc, pre-inc, plus working.
// - Pointer steps span all 12 bits with carry and leave flags alone.
`timescale 1ns/1ps
`default_nettype none

module dmag_addr_gen
    import dmag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dmag_req_t coreReq,
    output logic coreReady,
    output dmag_resp_t coreResp,
    output logic [BANK_W-1:0] bankSelect
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dmag_state_t fsm;
        logic [BANK_W-1:0] bank;
        logic [NUM_PTR-1:0][ADDR_W-1:0] ptr;
        logic isMove;
        logic zeroRead;
        logic [ADDR_W-1:0] curAddr;
        logic [ADDR_W-1:0] dstAddr;
        logic wbAck;
        logic [31:0] wbDat;
        dmag_resp_t resp;
    } dmag_core_t;

    dmag_core_t state_reg;
    dmag_core_t state_next;
    dmag_res_t res;
    logic [ADDR_W-1:0] rawAddr;
    logic [DATA_W-1:0] readVal;
    logic [7:0] wbWordAdr;
    logic wbTake;
    logic memRe;
    logic memWe;
    logic [RAM_AW-1:0] memAddr;
    logic [DATA_W-1:0] memWdata;
    logic [DATA_W-1:0] memRdata;

    // ------------------------------------------------------------------
    // Address helpers
    // ------------------------------------------------------------------

    // True when an address lands on one of the indirect port locations
    function automatic logic is_port(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a[11:5] == PORT_PAGE) && (a[4:3] < 2'(NUM_PTR))
            && (a[2:0] <= PK_OFFSET);
        return hit;
    endfunction

    // Implemented: low banks, plus the special register half of bank 15
    function automatic logic is_impl(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[11:8] < BANK_W'(IMPL_BANKS))
            || ((a[11:8] == SPECIAL_BANK) && a[7]);
        return ok;
    endfunction

    // Address bits 9:0 pick the RAM word; bank 15 maps a[6:0] above the low banks
    function automatic logic [RAM_AW-1:0] ram_index(
        input logic [ADDR_W-1:0] a
    );
        logic [RAM_AW-1:0] idx;
        if (a[11:8] == SPECIAL_BANK) begin
            idx = SPECIAL_RAM_BASE + RAM_AW'(a[6:0]);
        end else begin
            idx = a[RAM_AW-1:0];
        end
        return idx;
    endfunction

    // Turns a raw operand address into the effective one and the pointer
    // side effect; the port itself never reaches the RAM
    function automatic dmag_res_t resolve(
        input logic [ADDR_W-1:0] raw,
        input logic [NUM_PTR-1:0][ADDR_W-1:0] ptr,
        input logic [DATA_W-1:0] working
    );
        dmag_res_t r;
        logic [ADDR_W-1:0] p;
        logic [ADDR_W-1:0] ofs;
        r = '0;
        p = '0;
        ofs = {{(ADDR_W-DATA_W){working[DATA_W-1]}}, working};
        r.eff = raw;
        if (is_port(raw)) begin
            r.usePtr = 1'b1;
            r.ptrSel = raw[4:3];
            p = ptr[raw[4:3]];
            unique case (dmag_port_kind_t'(raw[2:0]))
                PK_PLAIN: begin
                    r.eff = p;
                end
                PK_AFTER_DOWN: begin
                    r.eff = p;
                    r.update = 1'b1;
                    r.ptrNew = p - 12'h001;
                end
                PK_AFTER_UP: begin
                    r.eff = p;
                    r.update = 1'b1;
                    r.ptrNew = p + 12'h001;
                end
                PK_BEFORE_UP: begin
                    r.eff = p + 12'h001;
                    r.update = 1'b1;
                    r.ptrNew = p + 12'h001;
                end
                PK_OFFSET: begin
                    r.eff = p + ofs;
                end
                default: begin
                    r.eff = p;
                end
            endcase
        end
        // Port targets read 00h / drop writes; so do missing banks
        r.blocked = is_port(r.eff) || !is_impl(r.eff);
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Core side first, bus writes last so software wins a same-cycle clash
    always_comb begin
        state_next = state_reg;
        state_next.wbAck = 1'b0;
        state_next.resp.done = 1'b0;
        memRe = 1'b0;
        memWe = 1'b0;
        memAddr = '0;
        memWdata = '0;
        rawAddr = '0;
        res = '0;
        readVal = '0;
        coreReady = (state_reg.fsm == ST_IDLE);
        wbTake = wb_cyc_i && wb_stb_i && !state_reg.wbAck;
        wbWordAdr = {wb_adr_i[7:2], 2'b00};

        unique case (state_reg.fsm)
            ST_IDLE: begin
                if (coreReq.valid) begin
                    // Operand address before any indirection
                    if (coreReq.op == OP_MOVE) begin
                        rawAddr = coreReq.srcAddr;
                    end else if (!coreReq.accessBit) begin
                        if (!coreReq.offset[7]) begin
                            rawAddr = {LOW_BANK, coreReq.offset};
                        end else begin
                            rawAddr = {SPECIAL_BANK, coreReq.offset};
                        end
                    end else begin
                        rawAddr = {state_reg.bank, coreReq.offset};
                    end
                    res = resolve(rawAddr, state_reg.ptr, coreReq.working);
                    unique case (coreReq.op)
                        OP_LOAD_BANK: begin
                            state_next.bank = coreReq.offset[BANK_W-1:0];
                            state_next.resp.done = 1'b1;
                            state_next.resp.blocked = 1'b0;
                            state_next.resp.addr = '0;
                            state_next.resp.rdata = '0;
                        end
                        OP_WRITE: begin
                            if (res.update) begin
                                state_next.ptr[res.ptrSel] = res.ptrNew;
                            end
                            memWe = !res.blocked;
                            memAddr = ram_index(res.eff);
                            memWdata = coreReq.wdata;
                            state_next.resp.done = 1'b1;
                            state_next.resp.blocked = res.blocked;
                            state_next.resp.addr = res.eff;
                            state_next.resp.rdata = '0;
                        end
                        OP_READ, OP_MOVE: begin
                            if (res.update) begin
                                state_next.ptr[res.ptrSel] = res.ptrNew;
                            end
                            memRe = !res.blocked;
                            memAddr = ram_index(res.eff);
                            state_next.zeroRead = res.blocked;
                            state_next.curAddr = res.eff;
                            state_next.isMove = (coreReq.op == OP_MOVE);
                            state_next.dstAddr = coreReq.dstAddr;
                            state_next.fsm = ST_READ;
                        end
                    endcase
                end
            end
            ST_READ: begin
                // Blocked reads answer zero; the ALU sets flags from it
                readVal = state_reg.zeroRead ? 8'h00 : memRdata;
                state_next.fsm = ST_IDLE;
                state_next.resp.done = 1'b1;
                if (state_reg.isMove) begin
                    // Destination resolved now, after any source step
                    res = resolve(state_reg.dstAddr, state_reg.ptr, 8'h00);
                    if (res.update) begin
                        state_next.ptr[res.ptrSel] = res.ptrNew;
                    end
                    memWe = !res.blocked;
                    memAddr = ram_index(res.eff);
                    memWdata = readVal;
                    state_next.resp.blocked = res.blocked;
                    state_next.resp.addr = res.eff;
                    state_next.resp.rdata = readVal;
                end else begin
                    state_next.resp.blocked = state_reg.zeroRead;
                    state_next.resp.addr = state_reg.curAddr;
                    state_next.resp.rdata = readVal;
                end
            end
        endcase

        // Wishbone slave: one-cycle registered ack, unmapped reads zero
        if (wbTake) begin
            state_next.wbAck = 1'b1;
            state_next.wbDat = 32'h0000_0000;
            if (wbWordAdr == WB_BANK_OFS) begin
                state_next.wbDat = 32'({4'h0, state_reg.bank});
                if (wb_we_i && wb_sel_i[0]) begin
                    state_next.bank = wb_dat_i[BANK_W-1:0];
                end
            end
            if (wbWordAdr == WB_STAT_OFS) begin
                state_next.wbDat = 32'(state_reg.resp.addr);
                state_next.wbDat[STAT_BUSY_BIT] =
                    (state_reg.fsm == ST_READ);
            end
            for (int i = 0; i < NUM_PTR; i++) begin
                if (wbWordAdr == 8'(WB_PTR0_OFS + WB_PTR_STRIDE * i)) begin
                    state_next.wbDat = 32'(state_reg.ptr[i]);
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.ptr[i][7:0] = wb_dat_i[7:0];
                    end
                    if (wb_we_i && wb_sel_i[1]) begin
                        state_next.ptr[i][11:8] = wb_dat_i[11:8];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Every control field has a constant reset value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.fsm <= ST_IDLE;
            state_reg.bank <= BANK_RESET;
            state_reg.ptr <= {NUM_PTR{PTR_RESET}};
            state_reg.isMove <= 1'b0;
            state_reg.zeroRead <= 1'b0;
            state_reg.curAddr <= '0;
            state_reg.dstAddr <= '0;
            state_reg.wbAck <= 1'b0;
            state_reg.wbDat <= 32'h0000_0000;
            state_reg.resp <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Storage and outputs
    // ------------------------------------------------------------------
    dmag_data_ram u_ram (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rdEn(memRe),
        .wrEn(memWe),
        .addr(memAddr),
        .wdata(memWdata),
        .rdata(memRdata)
    );

    assign wb_ack_o = state_reg.wbAck;
    assign wb_dat_o = state_reg.wbDat;
    assign coreResp = state_reg.resp;
    assign bankSelect = state_reg.bank;

endmodule

`default_nettype wire

// *** bench/dmag_addr_gen_checker.sv ***
// Port-level assertions for the data memory address generator
`timescale 1ns/1ps
`default_nettype none

module dmag_addr_gen_checker
    import dmag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire dmag_req_t coreReq,
    input wire logic coreReady,
    input wire dmag_resp_t coreResp,
    input wire logic [BANK_W-1:0] bankSelect
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // -------------------------------------------------------------
    // Take conditions
    // -------------------------------------------------------------
    logic wbTake, bankWr, coreTake, takeWr, takeRd, unimpl;
    assign wbTake = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bankWr = wbTake && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0];
    assign coreTake = coreReq.valid && coreReady;
    assign takeWr = coreTake && coreReq.op == OP_WRITE;
    assign takeRd = coreTake && coreReq.op == OP_READ;
    // Banks 2 to 14 have no storage behind them
    assign unimpl = bankSelect > 4'h1 && bankSelect < 4'hf;

    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    property p_bank_write;
        bankWr |=> bankSelect == $past(wb_dat_i[3:0]);
    endproperty
    a_bank_write: assert property (p_bank_write)
        else $error("bank write not applied");
    property p_bank_read;
        wbTake && !wb_we_i && wb_adr_i[7:2] == 6'h00 && !coreTake
            |=> wb_ack_o && wb_dat_o == {28'h000_0000, bankSelect};
    endproperty
    a_bank_read: assert property (p_bank_read)
        else $error("bank read value wrong");
    property p_load_bank;
        coreTake && coreReq.op == OP_LOAD_BANK && !bankWr
            |=> coreResp.done && bankSelect == $past(coreReq.offset[3:0]);
    endproperty
    a_load_bank: assert property (p_load_bank)
        else $error("bank load wrong");
    property p_win_low;
        takeWr && !coreReq.accessBit && !coreReq.offset[7]
            |=> coreResp.done && coreResp.addr == {4'h0, $past(coreReq.offset)};
    endproperty
    a_win_low: assert property (p_win_low)
        else $error("window low address wrong");
    property p_win_high;
        takeWr && !coreReq.accessBit && coreReq.offset[7] &&
            coreReq.offset < 8'he0
            |=> coreResp.addr == {4'hf, $past(coreReq.offset)};
    endproperty
    a_win_high: assert property (p_win_high)
        else $error("window high address wrong");
    property p_banked;
        takeWr && coreReq.accessBit && bankSelect != 4'hf
            |=> coreResp.addr == {$past(bankSelect), $past(coreReq.offset)};
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked address wrong");
    property p_unimpl_wr;
        takeWr && coreReq.accessBit && unimpl |=> coreResp.blocked;
    endproperty
    a_unimpl_wr: assert property (p_unimpl_wr)
        else $error("write to missing bank not dropped");
    property p_unimpl_rd;
        takeRd && coreReq.accessBit && unimpl |=> !coreReady
            ##1 coreResp.done && coreResp.blocked && coreResp.rdata == 8'h00;
    endproperty
    a_unimpl_rd: assert property (p_unimpl_rd)
        else $error("read of missing bank not zero");
    property p_move;
        coreTake && coreReq.op == OP_MOVE && coreReq.dstAddr < 12'hfe0
            |=> ##1 coreResp.done && coreResp.addr == $past(coreReq.dstAddr, 2);
    endproperty
    a_move: assert property (p_move)
        else $error("move destination wrong");

    // Main scenarios reached
    c_move: cover property (coreTake && coreReq.op == OP_MOVE);
    c_unimpl: cover property (takeRd && coreReq.accessBit && unimpl);
    c_bank_write: cover property (bankWr);
endmodule

bind dmag_addr_gen dmag_addr_gen_checker u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .coreReq(coreReq), .coreReady(coreReady),
    .coreResp(coreResp), .bankSelect(bankSelect)
);

`default_nettype wire

// *** bench/dmag_core_model.sv ***
// Behavioural model of the core's decoder issuing data accesses
`timescale 1ns/1ps
`default_nettype none

module dmag_core_model
    import dmag_pkg::*;
(
    input wire logic core_clk,
    input wire logic coreReady,
    input wire dmag_resp_t coreResp,
    output var dmag_req_t coreReq
);
    initial coreReq = '0;

    // Holds a request until taken, then waits a bounded time for done
    task automatic issue(input dmag_req_t req, output dmag_resp_t rsp,
                         output logic ok);
        dmag_req_t idle;
        int n;
        n = 0;
        @(posedge core_clk);
        coreReq <= req;
        do begin
            @(posedge core_clk);
            n++;
        end while (!coreReady && n < 50);
        // Released fields show garbage so stale values cannot be relied on
        idle = ~req;
        idle.valid = 1'b0;
        coreReq <= idle;
        while (coreResp.done !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        rsp = coreResp;
        ok = coreResp.done;
    endtask
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Directed testbench for the data memory address generator
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import dmag_pkg::*;
;
    logic core_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, coreReady, ok;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, rdat;
    logic [BANK_W-1:0] bankSelect;
    dmag_req_t coreReq;
    dmag_resp_t coreResp, rsp;
    int mismatches = 0;
    int checks = 0;

    dmag_addr_gen DUT (
        .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .coreReq(coreReq), .coreReady(coreReady),
        .coreResp(coreResp), .bankSelect(bankSelect)
    );
    dmag_core_model core (
        .core_clk(core_clk), .coreReady(coreReady),
        .coreResp(coreResp), .coreReq(coreReq)
    );

    // -------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbSel <= s;
        wbDatI <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        check("wb ack", 32'h1, 32'(wbAck));
    endtask

    task automatic op(input dmag_op_t o, input logic ab,
                      input logic [7:0] off, input logic [7:0] wd,
                      input logic [7:0] wk);
        dmag_req_t r;
        r = '{1'b1, o, ab, off, 12'h000, 12'h000, wd, wk};
        core.issue(r, rsp, ok);
        check("core done", 32'h1, 32'(ok));
    endtask

    // Indirect access, then the pointer read back over the bus
    task automatic ind(input dmag_op_t o, input logic [7:0] off,
                       input logic [7:0] wd, input logic [7:0] wk,
                       input logic [11:0] ea, input logic [11:0] ep);
        op(o, 1'b0, off, wd, wk);
        check("ind addr", 32'(ea), 32'(rsp.addr));
        wb(1'b0, 8'h04, 4'h0, 32'h0, rdat);
        check("pointer", 32'(ep), rdat);
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // Clock, watchdog and tests
    // -------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Run is under two hundred cycles; the watchdog fires after 5000
    initial begin
        #50us;
        mismatches++;
        $display("Error watchdog expected finish seen hang");
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        wb(1'b0, 8'h00, 4'h0, 32'h0, rdat);
        check("bank reset", 32'h0, rdat);
        wb(1'b0, 8'h1c, 4'h0, 32'h0, rdat);
        check("unmapped", 32'h0, rdat);
        wb(1'b1, 8'h00, 4'hf, 32'hffff_ffff, rdat);
        wb(1'b0, 8'h00, 4'h0, 32'h0, rdat);
        check("bank upper", 32'h0000_000f, rdat);
        $display("Test registers done");
        op(OP_LOAD_BANK, 1'b0, 8'h01, 8'h00, 8'h00);
        op(OP_WRITE, 1'b1, 8'h23, 8'ha5, 8'h00);
        check("banked addr", 32'h0000_0123, 32'(rsp.addr));
        op(OP_READ, 1'b1, 8'h23, 8'h00, 8'h00);
        check("banked data", 32'h0000_00a5, 32'(rsp.rdata));
        op(OP_WRITE, 1'b0, 8'h10, 8'h3c, 8'h00);
        check("window low", 32'h0000_0010, 32'(rsp.addr));
        op(OP_WRITE, 1'b0, 8'h90, 8'h5a, 8'h00);
        check("window high", 32'h0000_0f90, 32'(rsp.addr));
        check("bank kept", 32'h1, 32'(bankSelect));
        op(OP_LOAD_BANK, 1'b0, 8'h00, 8'h00, 8'h00);
        op(OP_READ, 1'b1, 8'h10, 8'h00, 8'h00);
        check("bank0 low", 32'h0000_003c, 32'(rsp.rdata));
        op(OP_LOAD_BANK, 1'b0, 8'h0f, 8'h00, 8'h00);
        op(OP_READ, 1'b1, 8'h90, 8'h00, 8'h00);
        check("bank15 high", 32'h0000_005a, 32'(rsp.rdata));
        $display("Test direct done");
        op(OP_LOAD_BANK, 1'b0, 8'h05, 8'h00, 8'h00);
        op(OP_WRITE, 1'b1, 8'h40, 8'h99, 8'h00);
        check("dropped write", 32'h1, 32'(rsp.blocked));
        op(OP_READ, 1'b1, 8'h40, 8'h00, 8'h00);
        check("zero read", 32'h0, 32'(rsp.rdata));
        core.issue('{1'b1, OP_MOVE, 1'b1, 8'h00, 12'h123, 12'h050,
                     8'h00, 8'h00}, rsp, ok);
        check("move addr", 32'h0000_0050, 32'(rsp.addr));
        check("move data", 32'h0000_00a5, 32'(rsp.rdata));
        op(OP_READ, 1'b0, 8'h50, 8'h00, 8'h00);
        check("moved byte", 32'h0000_00a5, 32'(rsp.rdata));
        $display("Test banks done");
        // Pointer straddles the byte boundary so every step must carry
        wb(1'b1, 8'h04, 4'h3, 32'h0000_00ff, rdat);
        ind(OP_WRITE, 8'he2, 8'h11, 8'h00, 12'h0ff, 12'h100);
        ind(OP_WRITE, 8'he1, 8'h22, 8'h00, 12'h100, 12'h0ff);
        ind(OP_READ, 8'he3, 8'h00, 8'h00, 12'h100, 12'h100);
        check("pre-inc data", 32'h0000_0022, 32'(rsp.rdata));
        ind(OP_READ, 8'he4, 8'h00, 8'hff, 12'h0ff, 12'h100);
        check("offset data", 32'h0000_0011, 32'(rsp.rdata));
        ind(OP_READ, 8'he0, 8'h00, 8'h00, 12'h100, 12'h100);
        wb(1'b1, 8'h08, 4'h3, 32'h0000_0fe0, rdat);
        op(OP_WRITE, 1'b0, 8'he8, 8'h77, 8'h00);
        check("port write", 32'h1, 32'(rsp.blocked));
        op(OP_READ, 1'b0, 8'he8, 8'h00, 8'h00);
        check("port read", 32'h0, 32'(rsp.rdata));
        wb(1'b0, 8'h10, 4'h0, 32'h0, rdat);
        check("status", 32'h0000_0fe0, rdat);
        $display("Test indirect done");
        test_done();
    end
endmodule

`default_nettype wire
